/* rtl/hliw_pkg.sv */
// Constants, field positions and state types of the host link inactivity watchdog.
package hliw_pkg;

  // ==========================================================================
  // Register offsets on the two-wire register bus.
  localparam logic [7:0] OFS_ALERT_LO   = 8'h10;
  localparam logic [7:0] OFS_ALERT_HI   = 8'h11;
  localparam logic [7:0] OFS_MASK_LO    = 8'h12;
  localparam logic [7:0] OFS_MASK_HI    = 8'h13;
  localparam logic [7:0] OFS_PORT_CTRL  = 8'h19;
  localparam logic [7:0] OFS_TERM_ROLE  = 8'h1a;
  localparam logic [7:0] OFS_FAULT      = 8'h1f;
  localparam logic [7:0] OFS_TIMER_SET  = 8'h84;

  // ==========================================================================
  // Field positions and masks.
  localparam int         ENABLE_BIT     = 5;
  localparam int         I2C_ERR_BIT    = 0;
  localparam int         FAULT_STAT_BIT = 1;
  localparam logic [3:0] ROLE_OPEN      = 4'hf;
  localparam logic [7:0] ALERT_HI_LIVE  = 8'ha7;
  localparam logic [7:0] ROLE_RW_MASK   = 8'h7f;
  localparam logic [7:0] TSET_RW_MASK   = 8'h03;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] RST_ALERT      = 8'h00;
  localparam logic [7:0] RST_MASK       = 8'hff;
  localparam logic [7:0] RST_PORT_CTRL  = 8'h00;
  localparam logic [7:0] RST_TERM_ROLE  = 8'h00;
  localparam logic [7:0] RST_FAULT      = 8'h00;
  localparam logic [7:0] RST_TIMER_SET  = 8'h00;

  // ==========================================================================
  // Timeout choices in milliseconds and their cycle counts at the core clock.
  localparam int CLK_KHZ   = 100000;
  localparam int TMO0_MS   = 1;
  localparam int TMO1_MS   = 2;
  localparam int TMO2_MS   = 4;
  localparam int TMO3_MS   = 8;
  localparam int TMO0_CYC  = TMO0_MS * CLK_KHZ;
  localparam int TMO1_CYC  = TMO1_MS * CLK_KHZ;
  localparam int TMO2_CYC  = TMO2_MS * CLK_KHZ;
  localparam int TMO3_CYC  = TMO3_MS * CLK_KHZ;
  localparam int CNT_W     = 24;

  // ==========================================================================
  // State types.
  typedef enum logic [2:0] {
    WD_IDLE  = 3'b001,
    WD_DISCH = 3'b010,
    WD_FLAG  = 3'b100
  } hliw_wd_state_t;

  typedef enum logic [4:0] {
    BUS_IDLE  = 5'b00001,
    BUS_DEV   = 5'b00010,
    BUS_REG   = 5'b00100,
    BUS_WDATA = 5'b01000,
    BUS_RDATA = 5'b10000
  } hliw_bus_state_t;

endpackage : hliw_pkg

/* rtl/hliw_timer.sv */
// Inactivity counter that fires once when its limit is reached.
`timescale 1ns/100ps
`default_nettype none
module hliw_timer (
  // Clock and reset.
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  // Control.
  input  wire logic                      run,
  input  wire logic                      restart,
  input  wire logic [hliw_pkg::CNT_W-1:0] limit,
  // Result.
  output logic                           expireStb
);

  logic [hliw_pkg::CNT_W-1:0] cnt_r;
  logic                       expired_r;

  // ==========================================================================
  // The last count before the limit is the expiry moment.
  wire atLimit = (cnt_r == limit - 1'b1);
  assign expireStb = run & ~restart & ~expired_r & atLimit;

  // Dropping run or a restart clears both count and latch, so a new start is fresh.
  always_ff @(posedge clk) begin
    if (!rst_b || !run || restart) begin
      cnt_r     <= '0;
      expired_r <= 1'b0;
    end else if (!expired_r) begin
      cnt_r     <= cnt_r + 1'b1;
      expired_r <= atLimit;
    end
  end

endmodule : hliw_timer
`default_nettype wire

/* rtl/hliw_i2c_slave.sv */
// Two-wire bus slave with register pointer, byte reads and byte writes.
`timescale 1ns/100ps
`default_nettype none
module hliw_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Bus pins.
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOe,
  // Register port.
  input  wire logic [7:0] rdData,
  output logic [7:0]      regPtr,
  output logic            wrStb,
  output logic [7:0]      wrAddr,
  output logic [7:0]      wrData,
  output logic            accessStb
);

  hliw_pkg::hliw_bus_state_t state_r;
  logic [2:0] sclSync_r;
  logic [2:0] sdaSync_r;
  logic [3:0] bitCnt_r;
  logic [7:0] rx_r;
  logic [7:0] tx_r;
  logic       nack_r;

  // ==========================================================================
  // Stage 0 feeds only stage 1; edges are taken from stages 1 and 2.
  always_ff @(posedge clk) begin
    sclSync_r <= {sclSync_r[1:0], sclIn};
    sdaSync_r <= {sdaSync_r[1:0], sdaIn};
  end

  wire sclRise  = sclSync_r[1] & ~sclSync_r[2];
  wire sclFall  = ~sclSync_r[1] & sclSync_r[2];
  wire sclHigh  = sclSync_r[1] & sclSync_r[2];
  wire startCnd = sclHigh & ~sdaSync_r[1] & sdaSync_r[2];
  wire stopCnd  = sclHigh & sdaSync_r[1] & ~sdaSync_r[2];
  wire match    = (rx_r[7:1] == DEV_ADDR);
  wire reading  = (state_r == hliw_pkg::BUS_RDATA);

  // ==========================================================================
  // Byte engine: bits move on the falling clock, acknowledge in the ninth slot.
  always_ff @(posedge clk) begin
    wrStb     <= 1'b0;
    accessStb <= 1'b0;
    if (!rst_b) begin
      state_r  <= hliw_pkg::BUS_IDLE;
      bitCnt_r <= 4'h0;
      sdaOe    <= 1'b0;
      regPtr   <= 8'h00;
      wrAddr   <= 8'h00;
      wrData   <= 8'h00;
      rx_r     <= 8'h00;
      tx_r     <= 8'h00;
      nack_r   <= 1'b0;
    end else if (startCnd) begin
      state_r  <= hliw_pkg::BUS_DEV;
      bitCnt_r <= 4'hf;
      sdaOe    <= 1'b0;
    end else if (stopCnd) begin
      state_r  <= hliw_pkg::BUS_IDLE;
      sdaOe    <= 1'b0;
    end else if (state_r != hliw_pkg::BUS_IDLE) begin
      if (sclRise && bitCnt_r == 4'h8) begin
        nack_r <= sdaSync_r[1];
      end else if (sclRise) begin
        rx_r <= {rx_r[6:0], sdaSync_r[1]};
      end
      if (sclFall && bitCnt_r == 4'hf) begin
        bitCnt_r <= 4'h0;  // The clock fall that closes a start carries no bit.
      end else if (sclFall && bitCnt_r < 4'h7) begin
        bitCnt_r <= bitCnt_r + 4'h1;
        if (reading) begin
          tx_r  <= {tx_r[6:0], 1'b0};
          sdaOe <= ~tx_r[6];
        end
      end else if (sclFall && bitCnt_r == 4'h7) begin
        bitCnt_r <= 4'h8;
        sdaOe    <= ~reading & (match | (state_r != hliw_pkg::BUS_DEV));
        case (state_r)
          hliw_pkg::BUS_DEV: begin
            accessStb <= match;
            if (!match) state_r <= hliw_pkg::BUS_IDLE;
          end
          hliw_pkg::BUS_REG: regPtr <= rx_r;
          hliw_pkg::BUS_WDATA: begin
            wrStb  <= 1'b1;
            wrAddr <= regPtr;
            wrData <= rx_r;
            regPtr <= regPtr + 8'h01;
          end
          hliw_pkg::BUS_RDATA: regPtr <= regPtr + 8'h01;
          default: state_r <= hliw_pkg::BUS_IDLE;
        endcase
      end else if (sclFall) begin
        bitCnt_r <= 4'h0;
        sdaOe    <= 1'b0;
        if ((state_r == hliw_pkg::BUS_DEV && rx_r[0]) || (reading && !nack_r)) begin
          state_r <= hliw_pkg::BUS_RDATA;
          tx_r    <= rdData;
          sdaOe   <= ~rdData[7];
        end else if (reading) begin
          state_r <= hliw_pkg::BUS_IDLE;
        end else if (state_r == hliw_pkg::BUS_DEV) begin
          state_r <= hliw_pkg::BUS_REG;
        end else begin
          state_r <= hliw_pkg::BUS_WDATA;
        end
      end
    end
  end

endmodule : hliw_i2c_slave
`default_nettype wire

/* rtl/hliw_top.sv */
// Host link inactivity watchdog with its alert, control and fault registers.
`timescale 1ns/100ps
`default_nettype none
module hliw_top #(
  parameter logic [6:0] DEV_ADDR = 7'h50,
  parameter int         TMO0_CYC = hliw_pkg::TMO0_CYC,
  parameter int         TMO1_CYC = hliw_pkg::TMO1_CYC,
  parameter int         TMO2_CYC = hliw_pkg::TMO2_CYC,
  parameter int         TMO3_CYC = hliw_pkg::TMO3_CYC
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Two-wire host bus.
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // Alert pin, open drain, pulled low while pending.
  output logic            alertOut,
  output logic            alertOe,
  // Event sources from the rest of the port controller.
  input  wire logic [7:0] alertSetLo,
  input  wire logic [7:0] alertSetHi,
  input  wire logic [7:1] faultSet,
  // Bus voltage comparator, high while below the safe level.
  input  wire logic       vbusBelowSafe,
  // Controls toward the port.
  output logic [7:0]      termRole,
  output logic [7:0]      portCtrl,
  output logic            vbusDischargeEn
);

  // ==========================================================================
  // Helpers.

  // Write-one-to-clear update in which a new event beats the clear.
  function automatic logic [7:0] w1c(input logic [7:0] cur,
                                     input logic [7:0] set,
                                     input logic [7:0] clr);
    w1c = (cur & ~clr) | set;
  endfunction : w1c

  // Timeout count chosen by the two-bit select field.
  function automatic logic [hliw_pkg::CNT_W-1:0] tmoCount(input logic [1:0] sel);
    case (sel)
      2'h0:    tmoCount = hliw_pkg::CNT_W'(TMO0_CYC);
      2'h1:    tmoCount = hliw_pkg::CNT_W'(TMO1_CYC);
      2'h2:    tmoCount = hliw_pkg::CNT_W'(TMO2_CYC);
      default: tmoCount = hliw_pkg::CNT_W'(TMO3_CYC);
    endcase
  endfunction : tmoCount

  // ==========================================================================
  // Declarations.
  logic [7:0] alertLo_r;
  logic [7:0] alertHi_r;
  logic [7:0] maskLo_r;
  logic [7:0] maskHi_r;
  logic [7:0] portCtrl_r;
  logic [7:0] role_r;
  logic [7:0] fault_r;
  logic [7:0] timerSet_r;
  logic [7:0] alertLo_nxt;
  logic [7:0] alertHi_nxt;
  logic [7:0] maskLo_nxt;
  logic [7:0] maskHi_nxt;
  logic [7:0] portCtrl_nxt;
  logic [7:0] role_nxt;
  logic [7:0] fault_nxt;
  logic [7:0] timerSet_nxt;
  logic       alertOe_r;
  logic [2:0] vbusSync_r;
  logic [7:0] regPtr;
  logic [7:0] rdData;
  logic       wrStb;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  logic       accessStb;
  logic       expireStb;
  hliw_pkg::hliw_wd_state_t wdState_r;
  hliw_pkg::hliw_wd_state_t wdState_nxt;

  // ==========================================================================
  // Bus slave.

  // The data line is only ever pulled low; the enable carries the bit.
  hliw_i2c_slave #(
    .DEV_ADDR  (DEV_ADDR)
  ) u_slave (
    .clk       (clk),
    .rst_b     (rst_b),
    .sclIn     (sclIn),
    .sdaIn     (sdaIn),
    .sdaOe     (sdaOe),
    .rdData    (rdData),
    .regPtr    (regPtr),
    .wrStb     (wrStb),
    .wrAddr    (wrAddr),
    .wrData    (wrData),
    .accessStb (accessStb)
  );

  assign sdaOut = 1'b0;

  // Write strobes, one per register.
  wire hitAlertLo = wrStb & (wrAddr == hliw_pkg::OFS_ALERT_LO);
  wire hitAlertHi = wrStb & (wrAddr == hliw_pkg::OFS_ALERT_HI);
  wire hitMaskLo  = wrStb & (wrAddr == hliw_pkg::OFS_MASK_LO);
  wire hitMaskHi  = wrStb & (wrAddr == hliw_pkg::OFS_MASK_HI);
  wire hitPort    = wrStb & (wrAddr == hliw_pkg::OFS_PORT_CTRL);
  wire hitRole    = wrStb & (wrAddr == hliw_pkg::OFS_TERM_ROLE);
  wire hitFault   = wrStb & (wrAddr == hliw_pkg::OFS_FAULT);
  wire hitTimer   = wrStb & (wrAddr == hliw_pkg::OFS_TIMER_SET);

  // Read selection; unmapped offsets read as zero.
  assign rdData =
    (regPtr == hliw_pkg::OFS_ALERT_LO)  ? alertLo_r  :
    (regPtr == hliw_pkg::OFS_ALERT_HI)  ? alertHi_r  :
    (regPtr == hliw_pkg::OFS_MASK_LO)   ? maskLo_r   :
    (regPtr == hliw_pkg::OFS_MASK_HI)   ? maskHi_r   :
    (regPtr == hliw_pkg::OFS_PORT_CTRL) ? portCtrl_r :
    (regPtr == hliw_pkg::OFS_TERM_ROLE) ? role_r     :
    (regPtr == hliw_pkg::OFS_FAULT)     ? fault_r    :
    (regPtr == hliw_pkg::OFS_TIMER_SET) ? timerSet_r :
    8'h00;

  // ==========================================================================
  // Alert and fault flags.

  // The watchdog raises the bus error flag only from its final step.
  wire i2cErrSet = (wdState_r == hliw_pkg::WD_FLAG);

  wire [7:0] faultNew = {faultSet, i2cErrSet};
  wire       faultEvt = |faultNew;

  // A fresh fault also posts the fault summary alert.
  wire [7:0] hiSet = (alertSetHi | {6'h00, faultEvt, 1'b0}) & hliw_pkg::ALERT_HI_LIVE;

  // Bits that read as fixed zero in the high half are kept out of set and clear.
  assign alertLo_nxt = w1c(alertLo_r, alertSetLo, hitAlertLo ? wrData : 8'h00);
  assign alertHi_nxt = w1c(alertHi_r, hiSet,
                           hitAlertHi ? (wrData & hliw_pkg::ALERT_HI_LIVE) : 8'h00);
  assign fault_nxt   = w1c(fault_r, faultNew, hitFault ? wrData : 8'h00);

  // Plain read-write registers.
  assign maskLo_nxt   = hitMaskLo ? wrData : maskLo_r;
  assign maskHi_nxt   = hitMaskHi ? wrData : maskHi_r;
  assign portCtrl_nxt = hitPort ? wrData : portCtrl_r;
  assign timerSet_nxt = hitTimer ? (wrData & hliw_pkg::TSET_RW_MASK) : timerSet_r;

  // Expiry overrides a host write landing in the same cycle.
  assign role_nxt = expireStb ? {role_r[7:4], hliw_pkg::ROLE_OPEN} :
                    hitRole   ? (wrData & hliw_pkg::ROLE_RW_MASK) :
                    role_r;

  // Register bank.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      alertLo_r  <= hliw_pkg::RST_ALERT;
      alertHi_r  <= hliw_pkg::RST_ALERT;
      maskLo_r   <= hliw_pkg::RST_MASK;
      maskHi_r   <= hliw_pkg::RST_MASK;
      portCtrl_r <= hliw_pkg::RST_PORT_CTRL;
      role_r     <= hliw_pkg::RST_TERM_ROLE;
      fault_r    <= hliw_pkg::RST_FAULT;
      timerSet_r <= hliw_pkg::RST_TIMER_SET;
    end else begin
      alertLo_r  <= alertLo_nxt;
      alertHi_r  <= alertHi_nxt;
      maskLo_r   <= maskLo_nxt;
      maskHi_r   <= maskHi_nxt;
      portCtrl_r <= portCtrl_nxt;
      role_r     <= role_nxt;
      fault_r    <= fault_nxt;
      timerSet_r <= timerSet_nxt;
    end
  end

  // ==========================================================================
  // Alert pin.

  // Pending means any unmasked flag; the pin follows one cycle behind the flags.
  wire alertPending = |(alertLo_r & maskLo_r) | |(alertHi_r & maskHi_r);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      alertOe_r <= 1'b0;
    end else begin
      alertOe_r <= alertPending;
    end
  end

  assign alertOut = 1'b0;
  assign alertOe  = alertOe_r;

  // ==========================================================================
  // Inactivity counter.

  wire wdEnable = portCtrl_r[hliw_pkg::ENABLE_BIT];

  // Counting needs the enable and a pending alert or driven alert pin; losing the enable, or both of the others, clears it.
  wire wdRun = wdEnable & (alertPending | alertOe_r);

  // Each addressed access restarts from zero while the alert is still pending.
  hliw_timer u_timer (
    .clk       (clk),
    .rst_b     (rst_b),
    .run       (wdRun),
    .restart   (accessStb),
    .limit     (tmoCount(timerSet_r[1:0])),
    .expireStb (expireStb)
  );

  // ==========================================================================
  // Bus voltage comparator crossing.

  // Stage 0 feeds only stage 1; the edge detector looks at stages 1 and 2.
  always_ff @(posedge clk) begin
    vbusSync_r <= {vbusSync_r[1:0], vbusBelowSafe};
  end

  wire vbusSafe     = vbusSync_r[1];
  wire vbusSafeRise = vbusSync_r[1] & ~vbusSync_r[2];

  // ==========================================================================
  // Expiry sequence.

  // Release happens on the drop below safe or on clearing the enable, so a later rise never
  // restarts the discharge; the host must take over from there.
  always_comb begin
    wdState_nxt = wdState_r;
    case (wdState_r)
      hliw_pkg::WD_IDLE: begin
        if (expireStb) begin
          wdState_nxt = vbusSafe ? hliw_pkg::WD_FLAG : hliw_pkg::WD_DISCH;
        end
      end
      hliw_pkg::WD_DISCH: begin
        if (!wdEnable) begin
          wdState_nxt = hliw_pkg::WD_IDLE;
        end else if (vbusSafeRise) begin
          wdState_nxt = hliw_pkg::WD_FLAG;
        end
      end
      hliw_pkg::WD_FLAG: begin
        wdState_nxt = hliw_pkg::WD_IDLE;
      end
      default: begin
        wdState_nxt = hliw_pkg::WD_IDLE;
      end
    endcase
  end

  // Sequence state.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wdState_r <= hliw_pkg::WD_IDLE;
    end else begin
      wdState_r <= wdState_nxt;
    end
  end

  // ==========================================================================
  // Outputs.

  // The discharge drive is a compare of the whole state register, so it is decoded from the flops.
  assign vbusDischargeEn = (wdState_r == hliw_pkg::WD_DISCH);
  assign termRole        = role_r;
  assign portCtrl        = portCtrl_r;

endmodule : hliw_top
`default_nettype wire

/* dv/hliw_top_chk.sv */
// Concurrent checks on the ports of the host link inactivity watchdog.
`timescale 1ns/100ps
`default_nettype none
module hliw_top_chk (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       rst_b,
  // Bus and alert pins.
  input wire logic       sclIn,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       alertOut,
  input wire logic       alertOe,
  // Event sources and comparator.
  input wire logic [7:0] alertSetLo,
  input wire logic [7:0] alertSetHi,
  input wire logic [7:1] faultSet,
  input wire logic       vbusBelowSafe,
  // Port controls.
  input wire logic [7:0] termRole,
  input wire logic [7:0] portCtrl,
  input wire logic       vbusDischargeEn
);
  // ==========================================================================
  // One clock domain, so clocking and reset are stated once.
  localparam int EN = hliw_pkg::ENABLE_BIT;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_off_no_disch: assert property (!portCtrl[EN] && !vbusDischargeEn |=> !vbusDischargeEn)
    else $error("discharge started while disabled");
  a_disch_opened: assert property ($rose(vbusDischargeEn) |-> portCtrl[EN] && termRole[3:0] == 4'hf)
    else $error("discharge began without open terminations");
  a_stop_on_safe: assert property (vbusDischargeEn && vbusBelowSafe |-> ##[1:4] !vbusDischargeEn)
    else $error("discharge kept on below safe level");
  a_stop_cause: assert property ($fell(vbusDischargeEn) |-> $past(vbusBelowSafe, 2) || !portCtrl[EN])
    else $error("discharge ended without cause");
  a_no_reengage: assert property ($fell(vbusDischargeEn) |=> !vbusDischargeEn [*8])
    else $error("discharge came back");
  a_fault_alert: assert property ($fell(vbusDischargeEn) && portCtrl[EN] |-> ##[1:3] alertOe)
    else $error("alert pin not raised after discharge");
  a_alert_fall: assert property ($fell(alertOe) |-> !sclIn)
    else $error("alert pin dropped outside a bus write");
  a_ack_edge: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("data line changed while bus clock high");
  a_pins_const: assert property (sdaOut == 1'b0 && alertOut == 1'b0 && termRole[7] == 1'b0)
    else $error("open drain level or role bit wrong");
endmodule : hliw_top_chk

bind hliw_top hliw_top_chk i_hliw_top_chk (.clk, .rst_b, .sclIn, .sdaIn, .sdaOut, .sdaOe, .alertOut,
  .alertOe, .alertSetLo, .alertSetHi, .faultSet, .vbusBelowSafe, .termRole, .portCtrl, .vbusDischargeEn);
`default_nettype wire

/* dv/hliw_host_model.sv */
// Two-wire bus master standing in for the port manager host.
`timescale 1ns/100ps
`default_nettype none
module hliw_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  // Clock.
  input  wire logic clk,
  // Data line level after the pull-up.
  input  wire logic sdaLine,
  // Lines driven by the host.
  output var logic  sclOut,
  output var logic  sdaLow
);
  // ==========================================================================
  // Both lines idle released; the bus clock stands still between frames.
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end

  // A quarter bit is four core edges, giving a 160 ns bus clock.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Start or repeated start: data falls while the clock is high.
  task automatic busStart();
    sdaLow <= 1'b0;
    tick(4);
    sclOut <= 1'b1;
    tick(4);
    sdaLow <= 1'b1;
    tick(4);
    sclOut <= 1'b0;
    tick(4);
  endtask : busStart

  // Stop: data rises while the clock is high, then the bus rests.
  task automatic busStop();
    sdaLow <= 1'b1;
    tick(4);
    sclOut <= 1'b1;
    tick(4);
    sdaLow <= 1'b0;
    tick(8);
  endtask : busStop

  // One bit: drive b (one releases), sample the wire mid-high.
  task automatic bitIo(input logic b, output logic s);
    sdaLow <= !b;
    tick(4);
    sclOut <= 1'b1;
    tick(4);
    s = sdaLine;
    tick(4);
    sclOut <= 1'b0;
    tick(4);
  endtask : bitIo

  // Eight bits MSB first, then the ninth bit b9 with its sampled level.
  task automatic byteIo(input logic [7:0] tx, input logic b9, output logic [7:0] rx, output logic s9);
    for (int i = 7; i >= 0; i--) begin
      bitIo(tx[i], rx[i]);
    end
    bitIo(b9, s9);
  endtask : byteIo

  // Byte write; recovery after an expiry is always started by the host here.
  task automatic writeReg(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic [2:0] s;
    busStart();
    byteIo({dev, 1'b0}, 1'b1, rx, s[0]);
    byteIo(p, 1'b1, rx, s[1]);
    byteIo(d, 1'b1, rx, s[2]);
    busStop();
    ok = (s === 3'b000);
  endtask : writeReg

  // Byte read through a repeated start, ended by a refusal of further data.
  task automatic readReg(input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic [2:0] s;
    logic       n;
    busStart();
    byteIo({DEV_ADDR, 1'b0}, 1'b1, rx, s[0]);
    byteIo(p, 1'b1, rx, s[1]);
    busStart();
    byteIo({DEV_ADDR, 1'b1}, 1'b1, rx, s[2]);
    byteIo(8'hff, 1'b1, d, n);
    busStop();
    ok = (s === 3'b000);
  endtask : readReg
endmodule : hliw_host_model
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the host link inactivity watchdog.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // ==========================================================================
  // Shortened timeouts keep the run brief; expectations follow these values.
  localparam int         T0  = 1000;
  localparam int         T3  = 2500;
  localparam logic [6:0] DEV = 7'h50;
  logic       clk;
  logic       rst_b;
  logic       sclIn;
  logic       sdaLow;
  logic       sdaOut;
  logic       sdaOe;
  logic       alertOut;
  logic       alertOe;
  logic       vbusBelowSafe;
  logic       vbusDischargeEn;
  logic [7:0] alertSetLo;
  logic [7:0] termRole;
  logic [7:0] portCtrl;
  wire        sdaLine;
  int         badCount = 0;
  int         testsRun = 0;
  int         cycles   = 0;
  int         tmo[4]   = '{T0, 1500, 2000, T3};

  // The data line is pulled up unless either party pulls it low.
  assign sdaLine = !(sdaLow || sdaOe);

  hliw_top #(.DEV_ADDR(DEV), .TMO0_CYC(T0), .TMO1_CYC(1500), .TMO2_CYC(2000), .TMO3_CYC(T3)) i_hliw_top (
    .clk, .rst_b, .sclIn, .sdaIn(sdaLine), .sdaOut, .sdaOe, .alertOut, .alertOe, .alertSetLo,
    .alertSetHi(8'h00), .faultSet(7'h00), .vbusBelowSafe, .termRole, .portCtrl, .vbusDischargeEn);
  hliw_host_model #(.DEV_ADDR(DEV)) i_hliw_host_model (.clk, .sdaLine, .sclOut(sclIn), .sdaLow);

  // Core clock at 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // A hang ends the run as a mismatch.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      badCount++;
      results();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic ok;
    i_hliw_host_model.writeReg(DEV, p, d, ok);
    check("ack", 8'h01, {7'h00, ok});
  endtask : wr

  task automatic rd(input logic [7:0] p, input logic [7:0] exp, input string what);
    logic [7:0] v;
    logic       ok;
    i_hliw_host_model.readReg(p, v, ok);
    check("ack", 8'h01, {7'h00, ok});
    check(what, exp, v);
  endtask : rd

  // One-cycle set pulse on the low alert sources.
  task automatic pulse(input logic [7:0] v);
    alertSetLo <= v;
    @(posedge clk);
    alertSetLo <= 8'h00;
    tick(4);
  endtask : pulse

  // Reset values, writable bits, an unmapped place and a foreign address.
  task automatic testReset();
    logic ok;
    check("portCtrl", hliw_pkg::RST_PORT_CTRL, portCtrl);
    check("termRole", hliw_pkg::RST_TERM_ROLE, termRole);
    rd(hliw_pkg::OFS_MASK_LO, hliw_pkg::RST_MASK, "maskLo");
    rd(8'h05, 8'h00, "unmapped");
    wr(hliw_pkg::OFS_TIMER_SET, 8'hff);
    rd(hliw_pkg::OFS_TIMER_SET, hliw_pkg::TSET_RW_MASK, "timerSetup");
    i_hliw_host_model.writeReg(7'h51, hliw_pkg::OFS_PORT_CTRL, 8'h20, ok);
    check("foreignAck", 8'h00, {7'h00, ok});
    check("portCtrl", 8'h00, portCtrl);
  endtask : testReset

  // A pending alert with the timer disabled never expires.
  task automatic testDisabled();
    pulse(8'h02);
    check("alertOe", 8'h01, {7'h00, alertOe});
    tick(T3 + 100);
    check("termRole", 8'h00, termRole);
  endtask : testDisabled

  // Every timeout choice: expiry time, open terminations, discharge and fault order.
  task automatic testExpire();
    int n;
    for (int s = 0; s < 4; s++) begin
      wr(hliw_pkg::OFS_TIMER_SET, 8'(s));
      n = 0;
      fork
        wr(hliw_pkg::OFS_PORT_CTRL, 8'h20);
        begin
          wait (portCtrl[hliw_pkg::ENABLE_BIT] === 1'b1);
          while (termRole[3:0] !== 4'hf && n < 3000) begin
            @(posedge clk);
            n++;
          end
        end
      join
      testsRun++;
      if (n < tmo[s] - 2 || n > tmo[s] + 3) begin
        badCount++;
        $display("wrong value expiryCycles expected %0d seen %0d", tmo[s], n);
      end
      check("termRole", 8'h0f, termRole);
      tick(2);
      check("discharge", 8'h01, {7'h00, vbusDischargeEn});
      rd(hliw_pkg::OFS_FAULT, 8'h00, "fault");
      vbusBelowSafe <= 1'b1;
      tick(8);
      check("discharge", 8'h00, {7'h00, vbusDischargeEn});
      rd(hliw_pkg::OFS_FAULT, 8'h01, "fault");
      rd(hliw_pkg::OFS_ALERT_HI, 8'h02, "alertHi");
      vbusBelowSafe <= 1'b0;
      tick(20);
      check("discharge", 8'h00, {7'h00, vbusDischargeEn});
      wr(hliw_pkg::OFS_PORT_CTRL, 8'h00);
      wr(hliw_pkg::OFS_FAULT, 8'h01);
      wr(hliw_pkg::OFS_ALERT_HI, 8'h02);
      wr(hliw_pkg::OFS_TERM_ROLE, 8'h00);
    end
  endtask : testExpire

  // Steady accesses hold off expiry; cleared or masked alerts do not count.
  task automatic testAccess();
    wr(hliw_pkg::OFS_TIMER_SET, 8'h00);
    wr(hliw_pkg::OFS_PORT_CTRL, 8'h20);
    repeat (4) rd(hliw_pkg::OFS_PORT_CTRL, 8'h20, "portCtrl");
    check("termRole", 8'h00, termRole);
    wr(hliw_pkg::OFS_ALERT_LO, 8'h02);
    tick(4);
    check("alertOe", 8'h00, {7'h00, alertOe});
    tick(T0 + 200);
    check("termRole", 8'h00, termRole);
    wr(hliw_pkg::OFS_MASK_LO, 8'h00);
    pulse(8'h04);
    tick(T0 + 200);
    check("alertOe", 8'h00, {7'h00, alertOe});
    check("termRole", 8'h00, termRole);
    rd(hliw_pkg::OFS_ALERT_LO, 8'h04, "alertLo");
  endtask : testAccess

  task automatic results();
    $display("checks %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // Main sequence after a four-cycle reset.
  initial begin
    rst_b = 1'b0;
    alertSetLo = 8'h00;
    vbusBelowSafe = 1'b0;
    tick(4);
    rst_b <= 1'b1;
    tick(3);
    testReset();
    testDisabled();
    testExpire();
    testAccess();
    results();
  end
endmodule : tb_top
`default_nettype wire
